// file: fbp_board.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Board side of the four pins: board drives where port does not
module fbp_board (
	input  wire logic [3:0] port_drive_in,
	input  wire logic [3:0] port_oe_in,
	input  wire logic [3:0] board_level_in,
	output logic      [3:0] pin_level_out
);
	// Port drive wins where enabled, else the board's level
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_level_out[i] = port_oe_in[i] ? port_drive_in[i]
				: board_level_in[i];
		end
	end
endmodule : fbp_board

// file: fbp_pkg.sv
package fbp_pkg;
	// Port geometry
	localparam int          PIN_COUNT        = 4;
	localparam int          FIRST_TIMER_CH   = 2;
	// Register indices (printed offset 0x9 is not a multiple of four)
	localparam logic [7:0]  IDX_LATCH        = 8'h09;
	localparam logic [7:0]  IDX_DIRECTION    = 8'h0A;
	localparam logic [7:0]  IDX_TIMER_SELECT = 8'h0B;
	// Byte addresses are four times the index
	localparam logic [11:0] ADDR_LATCH       = {2'b00, IDX_LATCH, 2'b00};
	localparam logic [11:0] ADDR_DIRECTION   = {2'b00, IDX_DIRECTION, 2'b00};
	localparam logic [11:0] ADDR_TIMER_SEL   = {2'b00, IDX_TIMER_SELECT, 2'b00};
	localparam int          ADDR_W           = 12;
	// Field layout of the timer select register: two bits per pin
	localparam int          ELS_W            = 2;
	localparam int          ELS_LOW_POS      = 0;
	localparam int          ELS_HIGH_POS     = 1;
	// Reset values
	localparam logic [3:0]  DIRECTION_RST    = 4'h0;
	localparam logic [7:0]  TIMER_SEL_RST    = 8'h00;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY        = 2'b00;
	localparam logic [1:0]  RESP_SLVERR      = 2'b10;
endpackage : fbp_pkg

// file: fbp_port.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - The port has four pins, each with its own data latch and direction bit.
// - Reset leaves the four data latches holding their previous value.
// - Reset clears all direction bits so every pin starts as an input.
// - Direction 1 drives the latch onto the pin, direction 0 leaves it an input.
// - A data read returns the latch for output bits and the pin for input bits.
// - Data writes with the low byte strobe set update the latches without disturbing input pins.
// - Pins 0..3 are timer channels 2..5, and in timer use direction does not drive.
// - In timer use the direction bit still selects latch or pin on a read.
// - Each channel's edge/level select field decides timer or port use of its pin.
// - All four direction bits are readable and writable by software.
module fbp_port #(
	parameter int PINS = fbp_pkg::PIN_COUNT
) (
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_n_in,
	// AXI4-Lite slave
	input  wire logic [fbp_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic                    s_axi_awvalid_in,
	output logic                         s_axi_awready_out,
	input  wire logic [31:0]             s_axi_wdata_in,
	input  wire logic [3:0]              s_axi_wstrb_in,
	input  wire logic                    s_axi_wvalid_in,
	output logic                         s_axi_wready_out,
	output logic [1:0]                   s_axi_bresp_out,
	output logic                         s_axi_bvalid_out,
	input  wire logic                    s_axi_bready_in,
	input  wire logic [fbp_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic                    s_axi_arvalid_in,
	output logic                         s_axi_arready_out,
	output logic [31:0]                  s_axi_rdata_out,
	output logic [1:0]                   s_axi_rresp_out,
	output logic                         s_axi_rvalid_out,
	input  wire logic                    s_axi_rready_in,
	// Pins
	input  wire logic [PINS-1:0]         pin_in,
	output logic [PINS-1:0]              pin_out,
	output logic [PINS-1:0]              pin_oe_out,
	// Timer channel side, channels 2..5 on pins 0..3
	input  wire logic [PINS-1:0]         timer_channel_pin_drive_in,
	input  wire logic [PINS-1:0]         timer_channel_pin_oe_in,
	output logic [PINS-1:0]              timer_channel_pin_level_out,
	output logic [PINS-1:0]              timer_channel_pin_active_out
);

	logic [PINS-1:0]         port_pin_data_latches_reg;
	logic [PINS-1:0]         port_pin_direction_reg;
	logic [2*PINS-1:0]       timer_select_reg;
	logic [PINS-1:0]         timer_use;
	logic [PINS-1:0]         data_read_value;
	logic [fbp_pkg::ADDR_W-1:0] awaddr_reg;
	logic [31:0]             wdata_reg;
	logic [3:0]              wstrb_reg;
	logic                    aw_held_reg;
	logic                    w_held_reg;
	logic                    wr_fire;
	logic                    wr_hit;

	////////////////////////////////////////////////////////////////////////
	// Timer use decode and read mux

	// A pin belongs to the timer when either edge/level select bit is set
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			timer_use[i] = |timer_select_reg[i*fbp_pkg::ELS_W +: fbp_pkg::ELS_W];
		end
	end

	// Direction picks latch or pin even in timer use
	assign data_read_value = (port_pin_direction_reg & port_pin_data_latches_reg)
		| (~port_pin_direction_reg & pin_in);

	////////////////////////////////////////////////////////////////////////
	// Write channel capture

	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
	assign wr_hit  = (awaddr_reg == fbp_pkg::ADDR_LATCH)
		|| (awaddr_reg == fbp_pkg::ADDR_DIRECTION)
		|| (awaddr_reg == fbp_pkg::ADDR_TIMER_SEL);

	// Address and data are taken in either order and held until the response
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_held_reg       <= 1'b0;
			w_held_reg        <= 1'b0;
			awaddr_reg        <= '0;
			wdata_reg         <= 32'h0000_0000;
			wstrb_reg         <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
		end else begin
			s_axi_awready_out <= !aw_held_reg && !s_axi_awready_out;
			s_axi_wready_out  <= !w_held_reg && !s_axi_wready_out;
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata_in;
				wstrb_reg  <= s_axi_wstrb_in;
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end
		end
	end

	// Write response follows both halves
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= fbp_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out  <= wr_hit ? fbp_pkg::RESP_OKAY : fbp_pkg::RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	// Data latches have no reset and take every write with the low byte strobe set
	always_ff @(posedge sys_clk_in) begin
		if (wr_fire && awaddr_reg == fbp_pkg::ADDR_LATCH && wstrb_reg[0]) begin
			port_pin_data_latches_reg <= wdata_reg[PINS-1:0];
		end
	end

	// Direction bits clear on reset
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port_pin_direction_reg <= fbp_pkg::DIRECTION_RST;
		end else if (wr_fire && awaddr_reg == fbp_pkg::ADDR_DIRECTION
			&& wstrb_reg[0]) begin
			port_pin_direction_reg <= wdata_reg[PINS-1:0];
		end
	end

	// Edge/level select fields, two bits per channel
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_select_reg <= fbp_pkg::TIMER_SEL_RST;
		end else if (wr_fire && awaddr_reg == fbp_pkg::ADDR_TIMER_SEL
			&& wstrb_reg[0]) begin
			timer_select_reg <= wdata_reg[2*PINS-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel, answer one cycle after the address is taken

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0000_0000;
			s_axi_rresp_out   <= fbp_pkg::RESP_OKAY;
		end else begin
			s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out
				&& !s_axi_arvalid_in ? 1'b1 : (!s_axi_rvalid_out && !s_axi_arready_out);
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out  <= 1'b1;
				s_axi_rresp_out   <= fbp_pkg::RESP_OKAY;
				s_axi_rdata_out   <= 32'h0000_0000;
				case (s_axi_araddr_in)
					fbp_pkg::ADDR_LATCH: begin
						s_axi_rdata_out[PINS-1:0] <= data_read_value;
					end
					fbp_pkg::ADDR_DIRECTION: begin
						s_axi_rdata_out[PINS-1:0] <= port_pin_direction_reg;
					end
					fbp_pkg::ADDR_TIMER_SEL: begin
						s_axi_rdata_out[2*PINS-1:0] <= timer_select_reg;
					end
					default: begin
						s_axi_rresp_out <= fbp_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers, registered

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_out                      <= '0;
			pin_oe_out                   <= '0;
			timer_channel_pin_level_out  <= '0;
			timer_channel_pin_active_out <= '0;
		end else begin
			for (int i = 0; i < PINS; i++) begin
				if (timer_use[i]) begin
					pin_out[i]    <= timer_channel_pin_drive_in[i];
					pin_oe_out[i] <= timer_channel_pin_oe_in[i];
				end else begin
					pin_out[i]    <= port_pin_data_latches_reg[i];
					pin_oe_out[i] <= port_pin_direction_reg[i];
				end
			end
			timer_channel_pin_level_out  <= pin_in;
			timer_channel_pin_active_out <= timer_use;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	property p_gpio_drive;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!timer_use[0] |=> pin_oe_out[0] == $past(port_pin_direction_reg[0]);
	endproperty
	a_gpio_drive: assert property (p_gpio_drive) else $error("gpio oe mismatch");

	property p_timer_drive;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		timer_use[1] |=> pin_oe_out[1] == $past(timer_channel_pin_oe_in[1]);
	endproperty
	a_timer_drive: assert property (p_timer_drive) else $error("timer oe ignored");

	property p_latch_write;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_fire && awaddr_reg == fbp_pkg::ADDR_LATCH && wstrb_reg[0]
		|=> port_pin_data_latches_reg == $past(wdata_reg[PINS-1:0]);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("latch not written");

	property p_dir_write;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_fire && awaddr_reg == fbp_pkg::ADDR_DIRECTION && wstrb_reg[0]
		|=> port_pin_direction_reg == $past(wdata_reg[PINS-1:0]);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction not written");

	property p_read_mux;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == fbp_pkg::ADDR_LATCH
		|=> s_axi_rvalid_out && s_axi_rdata_out[PINS-1:0] == $past(data_read_value);
	endproperty
	a_read_mux: assert property (p_read_mux) else $error("data read wrong");

	property p_upper_zero;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_axi_rvalid_out |-> s_axi_rdata_out[31:2*PINS] == '0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

	property p_sel_use;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		##1 timer_channel_pin_active_out == $past(timer_use);
	endproperty
	a_sel_use: assert property (p_sel_use) else $error("timer use mismatch");

	property p_read_in_timer;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		timer_use[2] && !port_pin_direction_reg[2] |-> data_read_value[2] == pin_in[2];
	endproperty
	a_read_in_timer: assert property (p_read_in_timer) else $error("timer read");

	property p_reset_dir;
		@(posedge sys_clk_in) $rose(rst_n_in) |-> port_pin_direction_reg == '0;
	endproperty
	a_reset_dir: assert property (p_reset_dir) else $error("direction not cleared");

	// Direction read returns the bits and an OKAY response
	property p_dir_read;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_axi_arvalid_in && s_axi_arready_out
			&& s_axi_araddr_in == fbp_pkg::ADDR_DIRECTION
		|=> s_axi_rdata_out[PINS-1:0] == $past(port_pin_direction_reg)
			&& s_axi_rresp_out == fbp_pkg::RESP_OKAY;
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("dir read");

	property p_sel_write;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_fire && awaddr_reg == fbp_pkg::ADDR_TIMER_SEL && wstrb_reg[0]
		|=> timer_select_reg == $past(wdata_reg[2*PINS-1:0]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select write");

	// Unmapped reads give an error response and all-zero data
	property p_unmapped;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_axi_arvalid_in && s_axi_arready_out
			&& s_axi_araddr_in != fbp_pkg::ADDR_LATCH
			&& s_axi_araddr_in != fbp_pkg::ADDR_DIRECTION
			&& s_axi_araddr_in != fbp_pkg::ADDR_TIMER_SEL
		|=> s_axi_rresp_out == fbp_pkg::RESP_SLVERR && s_axi_rdata_out == '0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");

	// Capture side sees the pin one cycle late, skipped on the release edge
	property p_timer_level;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		$past(rst_n_in) |-> timer_channel_pin_level_out == $past(pin_in);
	endproperty
	a_timer_level: assert property (p_timer_level) else $error("pin level");

endmodule : fbp_port

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, r32;
	logic [3:0]  wstrb, board, tdrv, toe, lat, dir, tact;
	logic [7:0]  sel;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [3:0]  pin_lvl, pin_o, pin_oe, t_lvl, t_act;
	int          miscompares, comparisons;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	////////////////////////////////////////////////////////////////
	fbp_port uut (
		.sys_clk_in(clk), .rst_n_in(rst_n),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .pin_in(pin_lvl), .pin_out(pin_o),
		.pin_oe_out(pin_oe), .timer_channel_pin_drive_in(tdrv),
		.timer_channel_pin_oe_in(toe),
		.timer_channel_pin_level_out(t_lvl),
		.timer_channel_pin_active_out(t_act)
	);
	fbp_board board_model (.port_drive_in(pin_o), .port_oe_in(pin_oe),
		.board_level_in(board), .pin_level_out(pin_lvl));
	////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// Expected drive enable and wire level from the mirror
	function logic [3:0] drv_e();
		return (tact & toe) | (~tact & dir);
	endfunction : drv_e
	function logic [3:0] pin_e();
		logic [3:0] v;
		v = (tact & tdrv) | (~tact & lat);
		return (drv_e() & v) | (~drv_e() & board);
	endfunction : pin_e
	function logic [33:0] rd_e();
		return {30'h0000_0000, (dir & lat) | (~dir & pin_e())};
	endfunction : rd_e
	// Verdict
	task complete_run();
		$display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	task tally(input logic [33:0] e, input logic [33:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : tally
	task cmp_rd(input logic [33:0] e, input logic [33:0] g);
		tally(e, g);
	endtask : cmp_rd
	task cmp_resp(input logic [1:0] e, input logic [1:0] g);
		tally({32'h0000_0000, e}, {32'h0000_0000, g});
	endtask : cmp_resp
	task cmp_pins(input logic [19:0] e, input logic [19:0] g);
		tally({14'h0000, e}, {14'h0000, g});
	endtask : cmp_pins
	task bound(input int n);
		if (n == 50) begin
			miscompares++;
			complete_run();
		end
	endtask : bound
	// Bus cycles: hold each channel until its ready is sampled
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge clk);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		bready <= 1'h0;
		bound(n);
	endtask : wr
	task rd(input logic [11:0] a, input logic [33:0] e);
		int n;
		@(posedge clk);
		rq.push_back(e);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		rready <= 1'h0;
		bound(n);
	endtask : rd
	task reset();
		rst_n <= 1'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
	endtask : reset
	task chk_pins();
		repeat (2) @(posedge clk);
		cmp_pins({tact, drv_e(), pin_e(), pin_e(),
			drv_e() & ((tact & tdrv) | (~tact & lat))},
			{t_act, pin_oe, pin_lvl, t_lvl, pin_oe & pin_o});
	endtask : chk_pins
	// Watcher: each answer is compared with the oldest note
	always @(posedge clk) begin
		if (rvalid && rready) cmp_rd(rq.pop_front(), {rresp, rdata});
		if (bvalid && bready) cmp_resp(bq.pop_front(), bresp);
	end
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb, board, tdrv, toe} = '0;
		{miscompares, comparisons, dir, tact} = '0;
		void'($urandom(35));
		wstrb = 4'hF;
		reset();
		rd(fbp_pkg::ADDR_DIRECTION, 34'h0);
		chk_pins();
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			board <= 4'($urandom);
			tdrv <= 4'($urandom);
			toe <= 4'($urandom);
			sel = (k == 0) ? 8'h00 : 8'($urandom);
			for (int i = 0; i < 4; i++) tact[i] = |sel[2*i +: 2];
			wr(fbp_pkg::ADDR_TIMER_SEL, {24'h00_0000, sel}, 2'h0);
			rd(fbp_pkg::ADDR_TIMER_SEL, {26'h000_0000, sel});
			r32 = $urandom;
			lat = r32[3:0];
			wr(fbp_pkg::ADDR_LATCH, r32, 2'h0);
			rd(fbp_pkg::ADDR_LATCH, rd_e());
			r32 = $urandom;
			dir = r32[3:0];
			wr(fbp_pkg::ADDR_DIRECTION, r32, 2'h0);
			chk_pins();
			rd(fbp_pkg::ADDR_DIRECTION, {30'h0, dir});
			rd(fbp_pkg::ADDR_LATCH, rd_e());
		end
		rd(12'h030, {2'h2, 32'h0000_0000});
		wr(12'h030, 32'hFFFF_FFFF, 2'h2);
		// A write without its low byte strobe leaves the direction bits alone
		wstrb <= 4'hE;
		wr(fbp_pkg::ADDR_DIRECTION, {28'h000_0000, ~dir}, 2'h0);
		rd(fbp_pkg::ADDR_DIRECTION, {30'h0, dir});
		wstrb <= 4'hF;
		reset();
		{dir, tact} = '0;
		rd(fbp_pkg::ADDR_DIRECTION, 34'h0);
		dir = 4'hF;
		wr(fbp_pkg::ADDR_DIRECTION, 32'h0000_000F, 2'h0);
		rd(fbp_pkg::ADDR_LATCH, rd_e());
		chk_pins();
		complete_run();
	end
endmodule : tb_top
